// >>> wwd_pkg.sv
// Shared constants, types and helpers for the windowed watchdog.
// Assumes a 100 MHz system clock and a 1.024 kHz watchdog tick made from it.
package wwd_pkg;

	// Clock rates; the watchdog tick is an enable pulse on clk
	localparam int CLK_HZ   = 100_000_000;
	localparam int OSC_HZ   = 1024;
	localparam int TICK_DIV = CLK_HZ / OSC_HZ;

	// Register bus geometry: 32-bit words, index times four is the byte address
	localparam int          ADDR_W      = 4;
	localparam logic [1:0]  IDX_CONTROL = 2'h0;
	localparam logic [1:0]  IDX_STATUS  = 2'h1;
	localparam logic [1:0]  IDX_PROTECT = 2'h2;
	localparam logic [1:0]  IDX_COUNT   = 2'h3;

	// Field positions and reset values
	localparam int          STAT_LOCK_BIT = 7;
	localparam int          STAT_PEND_BIT = 0;
	localparam logic [7:0]  CONTROL_RST   = 8'h00;
	localparam logic [7:0]  STATUS_RST    = 8'h00;

	// Timeout codes 0x1..0xB; above 0xB is reserved
	localparam logic [3:0]  CODE_OFF = 4'h0;
	localparam logic [3:0]  CODE_MIN = 4'h1;
	localparam logic [3:0]  CODE_MAX = 4'hB;
	localparam logic [13:0] BASE_LEN = 14'h0008;

	// Crossing and protection counts
	localparam logic [1:0]  CFG_SYNC_TICKS = 2'h2;
	localparam logic [1:0]  WDR_SYNC_TICKS = 2'h3;
	localparam logic [2:0]  PROT_WINDOW    = 3'h4;

	// Control register layout
	typedef struct packed {
		logic [3:0] window;
		logic [3:0] period;
	} wwd_cfg_type;

	// Watchdog counter states, one-hot
	typedef enum logic [3:0] {
		ST_OFF    = 4'b0001,
		ST_OPEN   = 4'b0010,
		ST_CLOSED = 4'b0100,
		ST_FIRE   = 4'b1000
	} wwd_state_type;

	// Length in ticks for a code; reserved codes saturate at the longest
	function automatic logic [13:0] wwd_len(input logic [3:0] code);
		logic [3:0] c;
		c = (code > CODE_MAX) ? CODE_MAX : code;
		if (c < CODE_MIN) begin
			c = CODE_MIN;
		end
		return BASE_LEN << (c - CODE_MIN);
	endfunction

endpackage

// >>> wwd_tick_div.sv
// Divider producing the watchdog oscillator tick as a one-cycle enable.
// Assumes one system clock; the tick stands in for the slow oscillator edge.
`timescale 1ns/1ps
`default_nettype none
module wwd_tick_div #(
	parameter int DIV = wwd_pkg::TICK_DIV
) (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic run,
	output logic      tick
);

	logic [16:0] cnt_r;

	// Free count while the oscillator is active; held when it stops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 17'h00000;
			tick  <= 1'b0;
		end else if (run) begin
			if (cnt_r == 17'(DIV - 1)) begin
				cnt_r <= 17'h00000;
				tick  <= 1'b1;
			end else begin
				cnt_r <= cnt_r + 17'h00001;
				tick  <= 1'b0;
			end
		end else begin
			tick <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// >>> wwd_top.sv
// Windowed watchdog with Avalon-MM register slave and reset request output.
// Assumes the fuse value is stable at reset release and inputs are on clk.
// Sleep is not an input: only the oscillator run input and debug halt stop the count.
//
// Summary of operation
// R1: Non-zero period field enables the watchdog
// R2: Zero window field means Normal mode
// R3: Normal mode timeout without clear requests reset
// R4: Accepted clear restarts the timeout period
// R5: Period codes 1..B select 8..8K ticks
// R6: Window codes use the same encoding
// R7: Clear during closed window requests reset
// R8: Open window follows closed; missed clear resets
// R9: First closed window starts after first clear
// R10: Clear syncs two-three ticks; extras ignored
// R11: Counter runs on 1.024 kHz oscillator tick
// R12: Control write sets sync pending until crossed
// R13: Software avoids control writes while pending
// R14: Protected writes need key then quick write
// R15: Unprotected writes to protected bits ignored
// R16: Lock only sets; clears in debug; locks control
// R17: Control resets from fuse; enabled fuse locks
// R18: Keeps running in sleep while oscillator runs
// R19: Debug halt stops counting and resets counter
// R20: Resume in Window mode runs Normal period first
// R21: Reset request held until system reset
`timescale 1ns/1ps
`default_nettype none
module wwd_top #(
	parameter int         TICK_DIV = wwd_pkg::TICK_DIV,
	parameter logic [7:0] IO_KEY   = 8'h5A
) (
	input  wire logic                       clk,
	input  wire logic                       rstn,
	input  wire logic [wwd_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [31:0]                avs_writedata,
	input  wire logic [3:0]                 avs_byteenable,
	output logic [31:0]                     avs_readdata,
	output logic                            avs_waitrequest,
	input  wire logic                       wdr_instr,
	input  wire logic                       debug_halt,
	input  wire logic                       debug_mode,
	input  wire logic                       osc_active,
	input  wire logic [7:0]                 fuse_cfg,
	output logic                            sys_reset_req,
	output logic                            wdog_enabled,
	output logic                            window_mode
);

	logic                   ack_r;
	logic                   boot_r;
	logic                   req;
	logic [1:0]             idx;
	logic                   wr_take;
	logic                   tick;
	logic                   wd_tick;
	wwd_pkg::wwd_cfg_type   ctrl_r;
	wwd_pkg::wwd_cfg_type   wd_cfg_r;
	wwd_pkg::wwd_cfg_type   fuse_view;
	wwd_pkg::wwd_cfg_type   new_cfg;
	logic                   lock_r;
	logic [2:0]             prot_cnt_r;
	logic                   prot_open;
	logic [1:0]             cfg_stage_r;
	logic                   sync_pending;
	logic                   cfg_load;
	logic                   cfg_defer;
	logic                   ctrl_write_ok;
	logic [1:0]             wdr_stage_r;
	logic                   wdr_fire;
	logic                   halted_r;
	wwd_pkg::wwd_state_type state_r;
	logic [13:0]            cnt_r;
	logic [13:0]            open_len;
	logic [13:0]            closed_len;
	logic                   fire_r;

	// Write accepted at one register index this cycle
	function automatic logic wr_hit(input logic [1:0] sel);
		return wr_take && (idx == sel);
	endfunction

	// A non-zero code turns its feature on
	function automatic logic code_on(input logic [3:0] code);
		return code != wwd_pkg::CODE_OFF;
	endfunction

	assign fuse_view = wwd_pkg::wwd_cfg_type'(fuse_cfg);
	assign new_cfg   = wwd_pkg::wwd_cfg_type'(avs_writedata[7:0]);

	// Oscillator tick; free of the CPU clock state, so sleep does not stop it
	wwd_tick_div #(
		.DIV (TICK_DIV)
	) u_div (
		.clk  (clk),
		.rstn (rstn),
		.run  (osc_active), // see R11 // see R18
		.tick (tick)
	);

	// Debug halt freezes the counter domain; the resume cycle is gated too,
	// since the state machine restarts then and would swallow a clear
	assign wd_tick = tick & ~debug_halt & ~halted_r; // see R19

	// Bus handshake: every access waits exactly one cycle
	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_r;
	assign idx             = avs_address[3:2];
	assign wr_take         = avs_write & ack_r & avs_byteenable[0];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end

	// Read data captured in the wait cycle so it stands at the accepting edge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read & ~ack_r) begin
			unique case (idx)
				wwd_pkg::IDX_CONTROL: begin
					avs_readdata <= {24'h000000, ctrl_r};
				end
				wwd_pkg::IDX_STATUS: begin
					avs_readdata <= {24'h000000, lock_r, 6'h00, sync_pending};
				end
				wwd_pkg::IDX_PROTECT: begin
					avs_readdata <= {31'h00000000, prot_open};
				end
				// One-hot state above the 14-bit count
				wwd_pkg::IDX_COUNT: begin
					avs_readdata <= {14'h0000, state_r, cnt_r};
				end
			endcase
		end
	end

	// Boot flag marks the first cycle after reset release
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			boot_r <= 1'b0;
		end else begin
			boot_r <= 1'b1;
		end
	end

	// Key write opens a short window for protected writes
	// A wrong key at this index is ignored and leaves no trace
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prot_cnt_r <= 3'h0;
		end else if (wr_hit(wwd_pkg::IDX_PROTECT) && avs_writedata[7:0] == IO_KEY) begin
			prot_cnt_r <= wwd_pkg::PROT_WINDOW; // see R14
		end else if (prot_cnt_r != 3'h0) begin
			prot_cnt_r <= prot_cnt_r - 3'h1;
		end
	end

	assign prot_open = (prot_cnt_r != 3'h0);

	// Pending writes are dropped rather than queued, a missed write is safer
	assign ctrl_write_ok = wr_hit(wwd_pkg::IDX_CONTROL) && prot_open // see R15
		&& !lock_r // see R16
		&& !sync_pending; // see R13

	// Control register; fuse value caught on the first clocked cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_r <= wwd_pkg::wwd_cfg_type'(wwd_pkg::CONTROL_RST);
		end else if (!boot_r) begin
			ctrl_r <= fuse_view; // see R17
		end else if (ctrl_write_ok) begin
			ctrl_r <= new_cfg;
		end
	end

	// Lock bit: protected, set-only outside debug
	// Writing zero outside debug leaves the lock set
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lock_r <= wwd_pkg::STATUS_RST[wwd_pkg::STAT_LOCK_BIT];
		end else if (!boot_r) begin
			lock_r <= code_on(fuse_view.period); // see R17
		end else if (wr_hit(wwd_pkg::IDX_STATUS) && prot_open) begin
			if (avs_writedata[wwd_pkg::STAT_LOCK_BIT]) begin
				lock_r <= 1'b1; // see R16
			end else if (debug_mode) begin
				lock_r <= 1'b0; // see R16
			end
		end
	end

	// Control crossing: copy at first tick, report done at the second
	// Writes are refused while pending, so a reload never meets the count-down
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_stage_r <= 2'h0;
		end else if (ctrl_write_ok) begin
			cfg_stage_r <= wwd_pkg::CFG_SYNC_TICKS; // see R12
		end else if (tick && cfg_stage_r != 2'h0 && !cfg_defer) begin
			cfg_stage_r <= cfg_stage_r - 2'h1; // see R12
		end
	end

	// A clear taking effect on the copy tick goes first; the copy waits a tick
	assign cfg_defer    = wdr_fire && (cfg_stage_r == wwd_pkg::CFG_SYNC_TICKS);
	assign sync_pending = (cfg_stage_r != 2'h0);
	assign cfg_load     = tick && (cfg_stage_r == wwd_pkg::CFG_SYNC_TICKS) && !cfg_defer;

	// Counter-side copy of the configuration
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wd_cfg_r <= wwd_pkg::wwd_cfg_type'(wwd_pkg::CONTROL_RST);
		end else if (!boot_r) begin
			wd_cfg_r <= fuse_view;
		end else if (cfg_load) begin
			wd_cfg_r <= ctrl_r;
		end
	end

	// Clear crossing; a clear arriving mid-sync is dropped
	// Its count-down uses gated ticks, so a pending clear waits out a halt
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wdr_stage_r <= 2'h0;
		end else if (wdr_instr && wdr_stage_r == 2'h0) begin
			wdr_stage_r <= wwd_pkg::WDR_SYNC_TICKS; // see R10
		end else if (wd_tick && wdr_stage_r != 2'h0) begin
			wdr_stage_r <= wdr_stage_r - 2'h1;
		end
	end

	// Takes effect on the third tick, two to three oscillator periods later
	assign wdr_fire = wd_tick && (wdr_stage_r == 2'h1); // see R10

	// Lengths of the open and closed windows in ticks
	// Reserved codes run as the longest length rather than stopping
	assign open_len   = wwd_pkg::wwd_len(wd_cfg_r.period); // see R5
	assign closed_len = wwd_pkg::wwd_len(wd_cfg_r.window); // see R6

	// Remember a debug halt so resume can restart cleanly
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			halted_r <= 1'b0;
		end else begin
			halted_r <= debug_halt;
		end
	end

	// Watchdog counter state machine, advanced on oscillator ticks
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= wwd_pkg::ST_OFF; // see R21
			cnt_r   <= 14'h0000;
		end else if (!boot_r) begin
			cnt_r <= 14'h0000;
			if (code_on(fuse_view.period)) begin
				state_r <= wwd_pkg::ST_OPEN; // see R1
			end else begin
				state_r <= wwd_pkg::ST_OFF;
			end
		end else if (state_r == wwd_pkg::ST_FIRE) begin
			state_r <= wwd_pkg::ST_FIRE; // see R21
		end else if (debug_halt || halted_r) begin
			// Halted or just resumed: counter cleared, open period first
			cnt_r <= 14'h0000; // see R19
			if (code_on(wd_cfg_r.period)) begin
				state_r <= wwd_pkg::ST_OPEN; // see R20 // see R9
			end else begin
				state_r <= wwd_pkg::ST_OFF;
			end
		end else if (cfg_load) begin
			// Turning on, or entering window mode, starts fresh in the open period;
			// a change of lengths alone keeps the running count
			if (ctrl_r.period == wwd_pkg::CODE_OFF) begin
				state_r <= wwd_pkg::ST_OFF; // see R1
				cnt_r   <= 14'h0000;
			end else if (state_r == wwd_pkg::ST_OFF
				|| (wd_cfg_r.window == wwd_pkg::CODE_OFF
				&& ctrl_r.window != wwd_pkg::CODE_OFF)) begin
				state_r <= wwd_pkg::ST_OPEN; // see R9
				cnt_r   <= 14'h0000;
			end
		end else if (wd_tick) begin
			unique case (state_r)
				wwd_pkg::ST_OFF: begin
					cnt_r <= 14'h0000;
				end
				wwd_pkg::ST_OPEN: begin
					if (wdr_fire) begin
						cnt_r <= 14'h0000; // see R4
						if (wd_cfg_r.window != wwd_pkg::CODE_OFF) begin
							state_r <= wwd_pkg::ST_CLOSED; // see R2 // see R9
						end
					end else if (cnt_r == open_len - 14'h0001) begin
						state_r <= wwd_pkg::ST_FIRE; // see R3 // see R8
					end else begin
						cnt_r <= cnt_r + 14'h0001;
					end
				end
				wwd_pkg::ST_CLOSED: begin
					if (wdr_fire) begin
						state_r <= wwd_pkg::ST_FIRE; // see R7
					end else if (cnt_r == closed_len - 14'h0001) begin
						state_r <= wwd_pkg::ST_OPEN; // see R8
						cnt_r   <= 14'h0000;
					end else begin
						cnt_r <= cnt_r + 14'h0001;
					end
				end
				wwd_pkg::ST_FIRE: begin
					state_r <= wwd_pkg::ST_FIRE;
				end
			endcase
		end
	end

	// Reset request latched until rstn drops
	// Registered so the reset controller sees a clean level
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fire_r <= 1'b0;
		end else if (state_r == wwd_pkg::ST_FIRE) begin
			fire_r <= 1'b1; // see R21
		end
	end

	// Status outputs from the counter-side settings
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wdog_enabled <= 1'b0;
			window_mode  <= 1'b0;
		end else begin
			wdog_enabled <= code_on(wd_cfg_r.period); // see R1
			window_mode  <= code_on(wd_cfg_r.window); // see R2
		end
	end

	assign sys_reset_req = fire_r;

endmodule
`default_nettype wire

// >>> wwd_assertions.sv
// Checker for the windowed watchdog, bound to its top module.
// Assumes the bus master holds each request until waitrequest is low.
`timescale 1ns/1ps
`default_nettype none
module wwd_assertions #(
	parameter int TICK_DIV = 4
) (
	input wire logic                       clk,
	input wire logic                       rstn,
	input wire logic [wwd_pkg::ADDR_W-1:0] avs_address,
	input wire logic                       avs_read,
	input wire logic                       avs_write,
	input wire logic [31:0]                avs_readdata,
	input wire logic                       avs_waitrequest,
	input wire logic                       wdr_instr,
	input wire logic                       debug_halt,
	input wire logic                       sys_reset_req,
	input wire logic                       wdog_enabled,
	input wire logic                       window_mode
);
	logic [31:0] wr_gap_r;
	logic [31:0] quiet_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// Cycles since the last write; bounds how late a crossed value may show
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_gap_r <= 32'h0;
		end else if (avs_write) begin
			wr_gap_r <= 32'h0;
		end else if (wr_gap_r != 32'hFFFF) begin
			wr_gap_r <= wr_gap_r + 32'h1;
		end
	end

	// Cycles since a clear or a halt; saturates so it never wraps
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			quiet_r <= 32'h0;
		end else if (wdr_instr || debug_halt) begin
			quiet_r <= 32'h0;
		end else if (quiet_r != 32'hFFFF) begin
			quiet_r <= quiet_r + 32'h1;
		end
	end

	wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer not after one wait cycle");
	req_sticky_a: assert property (sys_reset_req |=> sys_reset_req)
		else $error("reset request dropped");
	fire_enabled_a: assert property ($rose(sys_reset_req) |-> $past(wdog_enabled))
		else $error("reset request while disabled");
	en_cross_a: assert property ($changed(wdog_enabled) |-> wr_gap_r <= 3*TICK_DIV+4)
		else $error("enable changed without a recent write");
	mode_cross_a: assert property ($changed(window_mode) |-> wr_gap_r <= 3*TICK_DIV+4)
		else $error("mode changed without a recent write");
	halt_quiet_a: assert property ($past(debug_halt, 3) && $past(debug_halt, 2)
		&& $past(debug_halt) |-> !$rose(sys_reset_req))
		else $error("reset request while halted");
	normal_len_a: assert property ($rose(sys_reset_req) && !window_mode
		&& wr_gap_r > 3*TICK_DIV+4 |-> quiet_r >= 7*TICK_DIV)
		else $error("normal timeout shorter than shortest period");
	status_zero_a: assert property (avs_read && !avs_waitrequest
		&& avs_address[3:2] == wwd_pkg::IDX_STATUS |-> avs_readdata[31:1] == 31'h0
		|| avs_readdata[31:1] == 31'h40)
		else $error("status reserved bits not zero");
endmodule

bind wwd_top wwd_assertions #(.TICK_DIV(TICK_DIV)) u_chk (
	.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.wdr_instr(wdr_instr), .debug_halt(debug_halt), .sys_reset_req(sys_reset_req),
	.wdog_enabled(wdog_enabled), .window_mode(window_mode)
);
`default_nettype wire

// >>> wwd_far_model.sv
// Far side model: core issuing clear pulses, and the reset controller.
// Assumes the bench raises clr_go for one cycle per clear instruction.
`timescale 1ns/1ps
`default_nettype none
module wwd_far_model (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic clr_go,
	input  wire logic sys_reset_req,
	output logic      wdr_instr,
	output logic      rst_seen
);
	// One clock-wide clear pulse per request
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wdr_instr <= 1'b0;
		end else begin
			wdr_instr <= clr_go;
		end
	end

	// Controller notes the request; only a system reset clears it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_seen <= 1'b0;
		end else begin
			rst_seen <= rst_seen | sys_reset_req;
		end
	end
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the windowed watchdog over Avalon-MM.
// Assumes a short tick divider so every timeout fits a brief run.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int         TD  = 4;
	localparam logic [7:0] KEY = 8'h5A;
	logic        clk   = 1'b0;
	logic        rstn  = 1'b0;
	logic [3:0]  adr   = 4'h0;
	logic        rq_rd = 1'b0;
	logic        rq_wr = 1'b0;
	logic [31:0] wdat  = 32'h0;
	logic [31:0] rdat;
	logic        wreq;
	logic        go    = 1'b0;
	logic        dh    = 1'b0;
	logic        dm    = 1'b0;
	logic        osc   = 1'b1;
	logic [7:0]  fuse  = 8'h00;
	logic        watchdog_clear_instr;
	logic        srr;
	logic        en;
	logic        wm;
	logic        seen;
	int          miscompares = 0;
	int          tests_run = 0;

	wwd_top #(.TICK_DIV(TD), .IO_KEY(KEY)) DUT (
		.clk(clk), .rstn(rstn), .avs_address(adr), .avs_read(rq_rd), .avs_write(rq_wr),
		.avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdat),
		.avs_waitrequest(wreq), .wdr_instr(watchdog_clear_instr), .debug_halt(dh), .debug_mode(dm),
		.osc_active(osc), .fuse_cfg(fuse), .sys_reset_req(srr), .wdog_enabled(en),
		.window_mode(wm)
	);
	wwd_far_model u_far (
		.clk(clk), .rstn(rstn), .clr_go(go), .sys_reset_req(srr), .wdr_instr(watchdog_clear_instr),
		.rst_seen(seen)
	);

	// Free-running 100 MHz clock
	initial begin
		forever #5 clk = ~clk;
	end

	task automatic ck(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	// One bus cycle; held to the edge that sees waitrequest low, released there.
	// A hang here is left to the time limit below, which ends the run.
	task automatic bus(input logic w, input logic [1:0] i, input logic [7:0] d,
		output logic [7:0] q);
		adr <= {i, 2'h0};
		wdat <= {24'h0, d};
		rq_wr <= w;
		rq_rd <= !w;
		do begin
			@(posedge clk);
		end while (wreq !== 1'b0);
		q = rdat[7:0];
		rq_wr <= 1'b0;
		rq_rd <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rc(input logic [1:0] i, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, i, 8'h00, q);
		ck(q, e);
	endtask

	task automatic pw(input logic [1:0] i, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, 2'h2, KEY, q);
		bus(1'b1, i, d, q);
	endtask

	// Software waits out the crossing before touching control again
	task automatic sy;
		logic [7:0] q;
		int n;
		n = 0;
		do begin
			bus(1'b0, 2'h1, 8'h00, q);
			n++;
		end while (q[0] !== 1'b0 && n < 30);
		ck({7'h0, q[0]}, 8'h00);
	endtask

	task automatic tk(input int n);
		repeat (n * TD) @(posedge clk);
	endtask

	task automatic clr;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rst(input logic [7:0] f);
		rstn <= 1'b0;
		fuse <= f;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Cuts a hang short well beyond the expected run length
	initial begin
		#300_000;
		ck(8'h00, 8'h01);
		summarize();
	end

	initial begin
		logic [7:0] q;
		int c;
		int l;
		rst(8'h00);
		rc(2'h0, 8'h00);
		rc(2'h1, 8'h00);
		bus(1'b1, 2'h0, 8'h01, q);
		rc(2'h0, 8'h00);
		bus(1'b1, 2'h2, 8'hA5, q);
		rc(2'h2, 8'h00);
		bus(1'b1, 2'h2, KEY, q);
		rc(2'h2, 8'h01);
		pw(2'h0, 8'h01);
		rc(2'h1, 8'h01);
		sy();
		ck({7'h0, en}, 8'h01);
		ck({7'h0, wm}, 8'h00);
		$display("test config done");
		for (c = 1; c < 5; c++) begin
			l = 8 << (c - 1);
			rst(8'h00);
			pw(2'h0, c[7:0]);
			sy();
			repeat (2) begin
				clr();
				tk(6);
			end
			clr();
			tk(l + 1);
			ck({7'h0, seen}, 8'h00);
			tk(3);
			ck({7'h0, seen}, 8'h01);
		end
		rst(8'h00);
		pw(2'h0, 8'h01);
		sy();
		osc <= 1'b0;
		tk(40);
		ck({7'h0, seen}, 8'h00);
		osc <= 1'b1;
		tk(12);
		ck({7'h0, seen}, 8'h01);
		$display("test period done");
		rst(8'h00);
		ck({7'h0, srr}, 8'h00);
		pw(2'h0, 8'h11);
		sy();
		ck({7'h0, wm}, 8'h01);
		clr();
		clr();
		tk(12);
		clr();
		tk(4);
		ck({7'h0, seen}, 8'h00);
		clr();
		tk(5);
		ck({7'h0, seen}, 8'h01);
		rst(8'h00);
		pw(2'h0, 8'h11);
		sy();
		clr();
		tk(17);
		ck({7'h0, seen}, 8'h00);
		tk(3);
		ck({7'h0, seen}, 8'h01);
		rst(8'h00);
		pw(2'h0, 8'h11);
		sy();
		clr();
		tk(5);
		dh <= 1'b1;
		tk(30);
		ck({7'h0, seen}, 8'h00);
		dh <= 1'b0;
		@(posedge clk);
		clr();
		tk(6);
		ck({7'h0, seen}, 8'h00);
		$display("test window done");
		rst(8'h00);
		pw(2'h1, 8'h80);
		rc(2'h1, 8'h80);
		pw(2'h0, 8'h01);
		rc(2'h0, 8'h00);
		pw(2'h1, 8'h00);
		rc(2'h1, 8'h80);
		dm <= 1'b1;
		pw(2'h1, 8'h00);
		rc(2'h1, 8'h00);
		dm <= 1'b0;
		bus(1'b1, 2'h1, 8'h80, q);
		rc(2'h1, 8'h00);
		rst(8'h21);
		rc(2'h1, 8'h80);
		rc(2'h0, 8'h21);
		ck({6'h0, wm, en}, 8'h03);
		$display("test lock done");
		summarize();
	end
endmodule
`default_nettype wire
